/* hw/sac_consts.svh */
// constants of the serial converter control link
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH

// ****************************************************************
// link framing
// ****************************************************************
`define SAC_CMD_BITS 4
`define SAC_RES_BITS 12
`define SAC_TX_BITS 5
`define SAC_CMD_SGL 3
`define SAC_CMD_ODD 2
`define SAC_CMD_HIGH_BIT_FIRST_SELECT 1
`define SAC_CMD_PS 0

// ****************************************************************
// timing
// ****************************************************************
`define SAC_CLK_PERIOD_NS 100
`define SAC_SCLK_MIN_PERIOD_NS 1000
`define SAC_HALF_CYC \
	((`SAC_SCLK_MIN_PERIOD_NS + 2 * `SAC_CLK_PERIOD_NS - 1) / \
	(2 * `SAC_CLK_PERIOD_NS))

// ****************************************************************
// host register map
// ****************************************************************
`define SAC_REG_CTRL 4'h0
`define SAC_REG_STATUS 4'h4
`define SAC_REG_DATA 4'h8
`define SAC_CTRL_GO 0
`define SAC_CTRL_SGL 1
`define SAC_CTRL_ODD 2
`define SAC_CTRL_HIGH_BIT_FIRST_SELECT 3
`define SAC_CTRL_PS 4
`define SAC_STAT_BUSY 0
`define SAC_STAT_DONE 1
`define SAC_ZERO32 32'h0000_0000

`endif

/* hw/sac_dev.sv */
// converter end of the serial link, clocked by the link clock
`timescale 1ns/10ps
`default_nettype none
`include "sac_consts.svh"
module sac_dev import sac_pkg::*; #(
	parameter int RES_BITS = `SAC_RES_BITS
) (
	input wire logic arst_n_i,
	sac_if.dev link,
	input wire logic [RES_BITS-1:0] sample_i,
	output logic cmd_valid_o,
	output sac_input_t plus_sel_o,
	output sac_input_t minus_sel_o,
	output logic high_bit_first_select_o,
	output logic shutdown_o
);
	localparam int CW = $clog2(2 * RES_BITS + 2);
	localparam logic [CW-1:0] LAST = CW'(2 * RES_BITS + 1);

	// ****************************************************************
	// declarations
	// ****************************************************************
	sac_dev_st_t st_r;
	logic [1:0] bit_cnt_r;
	logic [`SAC_CMD_BITS-1:0] cmd_r;
	logic [RES_BITS-1:0] res_r;
	logic [RES_BITS-1:0] sample_s;
	logic [CW-1:0] ocnt_r;
	logic link_rst_n;
	logic cmd_last;

	generate
		if (RES_BITS < 2 || RES_BITS > 16) begin : g_chk
			$error("sac_dev: result width must be 2 to 16");
		end
	endgenerate

	// select high holds every serial flop but shutdown and the sample synchroniser
	// in reset, so the link needs no edge of its own clock to clear a broken frame
	assign link_rst_n = arst_n_i & ~link.cs_n;
	assign cmd_last = (st_r == SAC_D_CMD) && (bit_cnt_r == 2'h3);

	// ****************************************************************
	// helpers
	// ****************************************************************
	// channel decode, single-ended measures against ground
	function automatic sac_input_t dec_plus(input logic sgl,
		input logic odd);
		dec_plus = odd ? SAC_IN_ONE : SAC_IN_ZERO;
	endfunction

	function automatic sac_input_t dec_minus(input logic sgl,
		input logic odd);
		if (sgl) begin
			dec_minus = SAC_IN_GND;
		end else begin
			dec_minus = odd ? SAC_IN_ZERO : SAC_IN_ONE;
		end
	endfunction

	// output bit for slot i: 0 null, then high-first word (all ones in shutdown), then
	// low-first copy unless high first is set or in shutdown, then zeros
	function automatic logic out_bit(input logic [CW-1:0] i,
		input logic [`SAC_CMD_BITS-1:0] cmd,
		input logic [RES_BITS-1:0] res);
		int k;
		k = int'(i);
		out_bit = 1'b0;
		if (k == 0) begin
			out_bit = 1'b0;
		end else if (k <= RES_BITS) begin
			if (!cmd[`SAC_CMD_PS]) begin
				out_bit = 1'b1;
			end else begin
				out_bit = res[RES_BITS - k];
			end
		end else if (k <= 2 * RES_BITS) begin
			if (cmd[`SAC_CMD_PS] && !cmd[`SAC_CMD_HIGH_BIT_FIRST_SELECT]) begin
				out_bit = res[k - RES_BITS - 1];
			end
		end
	endfunction

	// ****************************************************************
	// converter word into the link domain
	// ****************************************************************
	// the converter holds its word steady while select is low, so
	// a plain level crossing per bit is enough
	sac_sync #(
		.W(RES_BITS)
	) u_sample_sync (
		.clock_i(link.sclk),
		.arst_n_i(arst_n_i),
		.d_i(sample_i),
		.q_o(sample_s)
	);

	// ****************************************************************
	// command reception, rising edge
	// ****************************************************************
	always_ff @(posedge link.sclk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			st_r <= SAC_D_HUNT;
			bit_cnt_r <= 2'h0;
		end else begin
			case (st_r)
				SAC_D_HUNT: begin
					if (link.data) begin
						st_r <= SAC_D_CMD;
					end
				end
				SAC_D_CMD: begin
					bit_cnt_r <= bit_cnt_r + 2'h1;
					if (cmd_last) begin
						st_r <= SAC_D_DONE;
					end
				end
				SAC_D_DONE: begin
					st_r <= SAC_D_DONE;
				end
				default: begin
					st_r <= SAC_D_HUNT;
				end
			endcase
		end
	end

	always_ff @(posedge link.sclk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			cmd_r <= '0;
		end else if (st_r == SAC_D_CMD) begin
			cmd_r <= {cmd_r[`SAC_CMD_BITS-2:0], link.data};
		end
	end

	// result is sampled as the command completes
	always_ff @(posedge link.sclk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			res_r <= '0;
			cmd_valid_o <= 1'b0;
			plus_sel_o <= SAC_IN_ZERO;
			minus_sel_o <= SAC_IN_GND;
			high_bit_first_select_o <= 1'b0;
		end else if (cmd_last) begin
			res_r <= sample_s;
			cmd_valid_o <= 1'b1;
			plus_sel_o <= dec_plus(cmd_r[2], cmd_r[1]);
			minus_sel_o <= dec_minus(cmd_r[2], cmd_r[1]);
			high_bit_first_select_o <= cmd_r[0];
		end
	end

	// shutdown survives select high; only a new frame ends it
	always_ff @(posedge link.sclk or negedge arst_n_i) begin
		if (!arst_n_i) begin
			shutdown_o <= 1'b0;
		end else if (cmd_last) begin
			shutdown_o <= ~link.data;
		end else if (!link.cs_n && st_r == SAC_D_HUNT) begin
			shutdown_o <= 1'b0;
		end
	end

	// ****************************************************************
	// result transmission, falling edge
	// ****************************************************************
	always_ff @(negedge link.sclk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			link.dev_oe <= 1'b0;
			link.dev_do <= 1'b0;
			ocnt_r <= '0;
		end else if (st_r == SAC_D_DONE) begin
			link.dev_oe <= 1'b1;
			link.dev_do <= out_bit(ocnt_r, cmd_r, res_r);
			if (ocnt_r != LAST) begin
				ocnt_r <= ocnt_r + CW'(1);
			end
		end
	end
endmodule
`default_nettype wire

/* hw/sac_host.sv */
// host end: register-driven controller making the link clock
//
// Our own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "sac_consts.svh"
module sac_host import sac_pkg::*; #(
	parameter int HALF_CYC = `SAC_HALF_CYC
) (
	input wire logic clock_i,
	input wire logic arst_n_i,
	sac_if.host link,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o
);
	localparam int HW = $clog2(HALF_CYC + 1);

	// ****************************************************************
	// declarations
	// ****************************************************************
	sac_host_st_t st_r;
	logic [HW-1:0] half_r;
	logic [4:0] bits_r;
	logic [`SAC_TX_BITS-1:0] tx_r;
	logic [2*`SAC_RES_BITS-1:0] rx_r;
	logic [`SAC_CMD_BITS-1:0] cfg_r;
	logic done_r;
	logic data_s;
	logic tick;
	logic req;
	logic take;
	logic go;
	logic [4:0] nrx;

	generate
		if (HALF_CYC < 3) begin : g_chk
			$error("sac_host: half period must allow sync delay");
		end
	endgenerate

	assign tick = (half_r == HW'(HALF_CYC - 1));
	assign req = avs_read_i | avs_write_i;
	assign take = req & ~avs_waitrequest_o;
	assign go = take & avs_write_i & (avs_address_i == `SAC_REG_CTRL)
		& avs_writedata_i[`SAC_CTRL_GO] & (st_r == SAC_H_IDLE);
	assign nrx = cfg_r[`SAC_CMD_HIGH_BIT_FIRST_SELECT] ? 5'h0d : 5'h19;

	// returning data is a pin from outside this clock
	sac_sync #(
		.W(1)
	) u_data_sync (
		.clock_i(clock_i),
		.arst_n_i(arst_n_i),
		.d_i(link.data),
		.q_o(data_s)
	);

	// ****************************************************************
	// avalon slave, one wait state per access
	// ****************************************************************
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o <= `SAC_ZERO32;
		end else begin
			avs_waitrequest_o <= ~(req & avs_waitrequest_o);
			if (req & avs_waitrequest_o) begin
				case (avs_address_i)
					`SAC_REG_CTRL: avs_readdata_o <= {27'h000_0000,
						cfg_r[`SAC_CMD_PS], cfg_r[`SAC_CMD_HIGH_BIT_FIRST_SELECT],
						cfg_r[`SAC_CMD_ODD], cfg_r[`SAC_CMD_SGL], 1'b0};
					`SAC_REG_STATUS: avs_readdata_o <= {30'h0000_0000,
						done_r, st_r != SAC_H_IDLE};
					`SAC_REG_DATA: avs_readdata_o <= {8'h00, rx_r};
					default: avs_readdata_o <= `SAC_ZERO32;
				endcase
			end
		end
	end

	// ****************************************************************
	// half-period divider for the link clock
	// ****************************************************************
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			half_r <= '0;
		end else if (go || tick) begin
			half_r <= '0;
		end else begin
			half_r <= half_r + HW'(1);
		end
	end

	// ****************************************************************
	// frame sequencer: drive on falling, sample on rising
	// ****************************************************************
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_r <= SAC_H_IDLE;
			link.cs_n <= 1'b1;
			link.sclk <= 1'b0;
			link.host_do <= 1'b0;
			link.host_oe <= 1'b0;
			bits_r <= 5'h00;
			tx_r <= '0;
			rx_r <= '0;
			cfg_r <= '0;
			done_r <= 1'b0;
		end else begin
			case (st_r)
				SAC_H_IDLE: begin
					if (go) begin
						// kept in command-word order so the link
						// field positions index it directly
						cfg_r <= {avs_writedata_i[`SAC_CTRL_SGL],
							avs_writedata_i[`SAC_CTRL_ODD],
							avs_writedata_i[`SAC_CTRL_HIGH_BIT_FIRST_SELECT],
							avs_writedata_i[`SAC_CTRL_PS]};
						tx_r <= {1'b1, avs_writedata_i[`SAC_CTRL_SGL],
							avs_writedata_i[`SAC_CTRL_ODD],
							avs_writedata_i[`SAC_CTRL_HIGH_BIT_FIRST_SELECT],
							avs_writedata_i[`SAC_CTRL_PS]};
						link.cs_n <= 1'b0;
						link.host_do <= 1'b1;
						link.host_oe <= 1'b1;
						bits_r <= 5'h00;
						rx_r <= '0;
						done_r <= 1'b0;
						st_r <= SAC_H_SEND;
					end
				end
				SAC_H_SEND: begin
					if (tick) begin
						link.sclk <= ~link.sclk;
						if (!link.sclk) begin
							bits_r <= bits_r + 5'h01;
						end else if (bits_r == 5'h05) begin
							// hand the wire over to the converter
							link.host_oe <= 1'b0;
							bits_r <= 5'h00;
							if (!cfg_r[`SAC_CMD_PS]) begin
								link.cs_n <= 1'b1;
								st_r <= SAC_H_GAP;
							end else begin
								st_r <= SAC_H_RECV;
							end
						end else begin
							tx_r <= {tx_r[`SAC_TX_BITS-2:0], 1'b0};
							link.host_do <= tx_r[`SAC_TX_BITS-2];
						end
					end
				end
				SAC_H_RECV: begin
					if (tick) begin
						link.sclk <= ~link.sclk;
						if (!link.sclk) begin
							bits_r <= bits_r + 5'h01;
							if (bits_r != 5'h00) begin
								rx_r <= {rx_r[2*`SAC_RES_BITS-2:0], data_s};
							end
						end else if (bits_r == nrx) begin
							link.cs_n <= 1'b1;
							st_r <= SAC_H_GAP;
						end
					end
				end
				SAC_H_GAP: begin
					if (tick) begin
						done_r <= 1'b1;
						st_r <= SAC_H_IDLE;
					end
				end
				default: begin
					st_r <= SAC_H_IDLE;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

/* hw/sac_if.sv */
// three-wire link between host and converter
`timescale 1ns/10ps
`default_nettype none
interface sac_if;
	logic cs_n;
	logic sclk;
	logic host_do;
	logic host_oe;
	logic dev_do;
	logic dev_oe;
	logic data;

	// shared data wire; an undriven wire reads low here
	assign data = host_oe ? host_do : (dev_oe ? dev_do : 1'b0);

	modport host (output cs_n, output sclk, output host_do,
		output host_oe, input data);
	modport dev (input cs_n, input sclk, input data, output dev_do,
		output dev_oe);
endinterface
`default_nettype wire

/* hw/sac_pkg.sv */
// types shared by both ends of the serial converter link
package sac_pkg;
	typedef enum logic [1:0] {
		SAC_IN_ZERO = 2'h0,
		SAC_IN_ONE = 2'h1,
		SAC_IN_GND = 2'h2
	} sac_input_t;

	typedef enum logic [1:0] {
		SAC_D_HUNT = 2'h0,
		SAC_D_CMD = 2'h1,
		SAC_D_DONE = 2'h3
	} sac_dev_st_t;

	typedef enum logic [1:0] {
		SAC_H_IDLE = 2'h0,
		SAC_H_SEND = 2'h1,
		SAC_H_RECV = 2'h3,
		SAC_H_GAP = 2'h2
	} sac_host_st_t;
endpackage

/* hw/sac_sync.sv */
// two-flop level synchroniser
`timescale 1ns/10ps
`default_nettype none
module sac_sync #(
	parameter int W = 1
) (
	input wire logic clock_i,
	input wire logic arst_n_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_r;

	generate
		if (W < 1) begin : g_chk
			$error("sac_sync: width must be at least one");
		end
	endgenerate

	// first stage feeds only the second stage
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			meta_r <= '0;
			q_o <= '0;
		end else begin
			meta_r <= d_i;
			q_o <= meta_r;
		end
	end
endmodule
`default_nettype wire

/* tb/sac_link_asserts.sv */
// link checks between the host end and the converter end
`timescale 1ns/10ps
`default_nettype none
module sac_link_asserts (
	input wire logic clock_i,
	input wire logic arst_n_i,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic host_do,
	input wire logic host_oe,
	input wire logic dev_do,
	input wire logic dev_oe
);
	// ****************************************************************
	// link checks
	// ****************************************************************
	// sclk is made from clock_i, so every link event lands on its edges
	default clocking @(posedge clock_i); endclocking
	default disable iff (!arst_n_i);

	a_no_drive_clash: assert property (
		!(host_oe && dev_oe))
		else $error("both ends drive the data wire");
	a_hand_over: assert property (
		$rose(dev_oe) |-> $fell(host_oe))
		else $error("device drives before host lets go");
	a_null_first: assert property (
		$rose(dev_oe) |-> !dev_do)
		else $error("first device bit is not null");
	a_dev_on_fall: assert property (
		dev_oe && $past(dev_oe) && $changed(dev_do) |-> $fell(sclk))
		else $error("device data moved off a falling edge");
	a_host_on_fall: assert property (
		host_oe && $past(host_oe) && $changed(host_do) |-> $fell(sclk))
		else $error("host data moved off a falling edge");
	a_start_one: assert property (
		$fell(cs_n) |-> host_oe && host_do && !sclk)
		else $error("frame does not open with a start bit");
	a_frame_ends: assert property (
		$fell(cs_n) |-> ##[1:400] $rose(cs_n))
		else $error("select never rises after a frame");
	a_released_idle: assert property (
		cs_n |-> !dev_oe)
		else $error("device drives while deselected");
	a_sclk_idle: assert property (
		cs_n && $past(cs_n) |-> !sclk)
		else $error("link clock runs outside a frame");
	a_half_period: assert property (
		$rose(sclk) |-> sclk [*5] ##1 !sclk)
		else $error("link clock high phase has wrong length");
endmodule
`default_nettype wire

/* tb/serial_adc_control_interface_tb.sv */
// self-checking bench: host end and converter end on one link
`timescale 1ns/10ps
`default_nettype none
module serial_adc_control_interface_tb import sac_pkg::*;;
	// ****************************************************************
	// signals and instances
	// ****************************************************************
	logic clock_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic [3:0] addr = 4'h0;
	logic rd_en = 1'b0;
	logic wr_en = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic [31:0] rdata;
	logic waitreq;
	logic [11:0] sample = 12'h000;
	logic cmd_valid, hbf, shutdown;
	sac_input_t plus_sel, minus_sel;
	int miscompares = 0;
	int tests_run = 0;
	int rise_cnt = 0;
	// expected {plus, minus} indexed by {single, odd}
	logic [3:0] pm_exp [4] = '{{SAC_IN_ZERO, SAC_IN_ONE},
		{SAC_IN_ONE, SAC_IN_ZERO}, {SAC_IN_ZERO, SAC_IN_GND},
		{SAC_IN_ONE, SAC_IN_GND}};
	logic [11:0] smp_tab [4] = '{12'hFFF, 12'h001, 12'h800, 12'h5A5};

	sac_if link_if();
	sac_host sac_host_i (.clock_i(clock_i), .arst_n_i(arst_n_i),
		.link(link_if), .avs_address_i(addr), .avs_read_i(rd_en),
		.avs_write_i(wr_en), .avs_writedata_i(wdata),
		.avs_readdata_o(rdata), .avs_waitrequest_o(waitreq));
	sac_dev sac_dev_i (.arst_n_i(arst_n_i), .link(link_if),
		.sample_i(sample), .cmd_valid_o(cmd_valid),
		.plus_sel_o(plus_sel), .minus_sel_o(minus_sel),
		.high_bit_first_select_o(hbf), .shutdown_o(shutdown));
	sac_link_asserts sac_link_asserts_i (.clock_i(clock_i),
		.arst_n_i(arst_n_i), .cs_n(link_if.cs_n), .sclk(link_if.sclk),
		.host_do(link_if.host_do), .host_oe(link_if.host_oe),
		.dev_do(link_if.dev_do), .dev_oe(link_if.dev_oe));

	always #50 clock_i = ~clock_i;
	always @(posedge link_if.sclk) if (!link_if.cs_n) rise_cnt++;

	// ****************************************************************
	// tasks
	// ****************************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one avalon access; the request holds until waitrequest is seen low
	task automatic bus(input logic wr, input logic [3:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clock_i);
		addr <= a;
		wdata <= d;
		rd_en <= !wr;
		wr_en <= wr;
		do begin
			@(posedge clock_i);
			n++;
		end while (waitreq !== 1'b0 && n < 50);
		q = rdata;
		rd_en <= 1'b0;
		wr_en <= 1'b0;
		if (n >= 50) chk(32'h1, 32'h0);
	endtask

	// ctl is {power, high first, odd, single, go}
	task automatic frame(input logic [4:0] ctl, input logic [11:0] smp,
		input int edges, input logic [23:0] exp, input logic [23:0] mask);
		logic [31:0] q;
		int n;
		int c0;
		sample <= smp;
		c0 = rise_cnt;
		bus(1'b1, 4'h0, {27'h0, ctl}, q);
		n = 0;
		while (cmd_valid !== 1'b1 && n < 400) begin
			@(posedge clock_i);
			n++;
		end
		chk({28'h0, plus_sel, minus_sel},
			{28'h0, pm_exp[{ctl[1], ctl[2]}]});
		chk({31'h0, hbf}, {31'h0, ctl[3]});
		if (ctl[4]) chk({31'h0, shutdown}, 32'h0);
		n = 0;
		q = 32'h0;
		while (q[1] !== 1'b1 && n < 300) begin
			bus(1'b0, 4'h4, 32'h0, q);
			n++;
		end
		chk(q, 32'h2);
		chk(rise_cnt - c0, edges);
		chk({30'h0, link_if.cs_n, link_if.sclk}, 32'h2);
		chk({31'h0, cmd_valid}, 32'h0);
		chk({31'h0, shutdown}, {31'h0, !ctl[4]});
		bus(1'b0, 4'h8, 32'h0, q);
		chk({8'h0, q[23:0] & mask}, {8'h0, exp});
		bus(1'b0, 4'h0, 32'h0, q);
		chk(q, {27'h0, ctl[4:1], 1'b0});
	endtask

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ****************************************************************
	// tests
	// ****************************************************************
	initial begin
		logic [31:0] q;
		repeat (12) @(posedge clock_i);
		arst_n_i <= 1'b1;
		repeat (2) @(posedge clock_i);
		bus(1'b0, 4'h4, 32'h0, q);
		chk(q, 32'h0);
		bus(1'b1, 4'hC, 32'hFFFF_FFFF, q);
		bus(1'b0, 4'hC, 32'h0, q);
		chk(q, 32'h0);
		$display("register test done");
		for (int i = 0; i < 4; i++) begin
			frame({2'b11, i[0], i[1], 1'b1}, smp_tab[i], 18,
				{12'h000, smp_tab[i]}, 24'h00_0FFF);
		end
		$display("channel and high first test done");
		frame(5'h13, 12'h8C1, 30, 24'h8C1_831, 24'hFF_FFFF);
		$display("low first test done");
		// shutdown ends the frame right after the command
		frame(5'h0B, 12'h123, 5, 24'h00_0000, 24'h00_0000);
		frame(5'h1D, 12'h3C7, 18, 24'h00_03C7, 24'h00_0FFF);
		$display("shutdown test done");
		conclude();
	end

	// frames take about 60 to 310 cycles each
	initial begin
		repeat (20000) @(posedge clock_i);
		miscompares++;
		conclude();
	end
endmodule
`default_nettype wire
